// File: logic/ssw_cfg.svh
// named constants for the supply supervisor watchdog core
// assumes a single clock at the rate given below
`ifndef SSW_CFG_SVH
`define SSW_CFG_SVH

// clock and internal timebase
`define SSW_CLK_HZ        32'h017D_7840
`define SSW_HZ_PER_MHZ    32'h000F_4240
`define SSW_TICK_US       32'h0000_03E8
`define SSW_TICK_CYCLES   ((`SSW_CLK_HZ / `SSW_HZ_PER_MHZ) * `SSW_TICK_US)

// durations in internal ticks of one millisecond each
`define SSW_WD_SHORT_MS   16'h0064
`define SSW_WD_LONG_MS    16'h0640
`define SSW_RST_SHORT_MS  16'h0032
`define SSW_RST_LONG_MS   16'h00C8

// external timebase defaults, in rising edges of the timebase input
`define SSW_EXT_RST_TICKS 16'h0010
`define SSW_EXT_WD_SHORT  16'h0020
`define SSW_EXT_WD_LONG   16'h0200

// widths
`define SSW_CNT_W         16
`define SSW_PRESC_W       16
`define SSW_ADDR_W        8
`define SSW_PIN_W         8

// register map, byte addresses
`define SSW_REG_CTRL      8'h00
`define SSW_REG_STATUS    8'h04
`define SSW_REG_COUNT     8'h08

// control and status fields
`define SSW_CTRL_WD_EN    0
`define SSW_CTRL_RST      32'h0000_0001
`define SSW_ST_RESET_N    0
`define SSW_ST_SUPPLY_OK  1
`define SSW_ST_KICK_FLAG  2
`define SSW_ST_BACKUP     3
`define SSW_ST_WARN       4
`define SSW_ST_LONG       5
`define SSW_ST_EXT        6
`define SSW_ST_WD_ACTIVE  7

// bus answers
`define SSW_RESP_OKAY     2'h0
`define SSW_RESP_SLVERR   2'h2

`endif

// File: logic/ssw_pkg.sv
// types for the supply supervisor watchdog core
// assumes ssw_cfg.svh is on the include path
`include "ssw_cfg.svh"

package ssw_pkg;

  typedef enum logic {SSW_HOLD, SSW_RUN} ssw_phase_t;

  // pin levels, after synchronising
  typedef struct packed {
    logic supply_low;
    logic in_backup;
    logic warn_ok;
    logic kick_lvl;
    logic kick_float;
    logic tb_sel;
    logic tb_in;
    logic sel_in;
  } ssw_pins_t;

  typedef struct packed {
    logic [`SSW_PIN_W-1:0]   s1;
    logic [`SSW_PIN_W-1:0]   s2;
    logic [`SSW_PIN_W-1:0]   s3;
    ssw_pins_t               flt;
    logic [`SSW_PRESC_W-1:0] presc;
    logic                    tb_prev;
    logic                    kick_prev;
    logic                    float_prev;
    ssw_phase_t              phase;
    logic [`SSW_CNT_W-1:0]   rst_cnt;
    logic [`SSW_CNT_W-1:0]   wd_cnt;
    logic                    long_mode;
    logic                    kick_flag;
    logic                    reset_n;
    logic                    reset;
    logic                    supply_ok_n;
    logic                    backup_active;
    logic                    warn_out;
    logic                    sel_out;
    logic                    wd_en;
    logic                    aw_held;
    logic [`SSW_ADDR_W-1:0]  awaddr;
    logic                    w_held;
    logic [31:0]             wdata;
    logic [3:0]              wstrb;
    logic                    bvalid;
    logic [1:0]              bresp;
    logic                    rvalid;
    logic [31:0]             rdata;
    logic [1:0]              rresp;
  } ssw_state_t;

endpackage

// File: logic/ssw_top.sv
// supply supervisor and watchdog core with an AXI4-Lite register slave
// assumes comparator results arrive as asynchronous digital levels
`timescale 1ns/1ps
`include "ssw_cfg.svh"

module ssw_top #(
  parameter logic                    LONG_RESET    = 1'b0,
  parameter logic [`SSW_PRESC_W-1:0] TICK_CYCLES   =
    `SSW_PRESC_W'(`SSW_TICK_CYCLES),
  parameter logic [`SSW_CNT_W-1:0]   EXT_RST_TICKS = `SSW_EXT_RST_TICKS,
  parameter logic [`SSW_CNT_W-1:0]   EXT_WD_SHORT  = `SSW_EXT_WD_SHORT,
  parameter logic [`SSW_CNT_W-1:0]   EXT_WD_LONG   = `SSW_EXT_WD_LONG
) (
  input  wire logic                   aclk,
  input  wire logic                   aresetn,
  // pins
  input  wire logic                   supply_low_in,
  input  wire logic                   main_below_backup,
  input  wire logic                   early_warn_input,
  input  wire logic                   kick_input,
  input  wire logic                   kick_input_float,
  input  wire logic                   timebase_source_select,
  input  wire logic                   timebase_input,
  input  wire logic                   select_in,
  output logic                        reset_n,
  output logic                        reset,
  output logic                        supply_low_flag_n,
  output logic                        kick_timeout_flag,
  output logic                        backup_active_flag,
  output logic                        early_warn_output,
  output logic                        select_out,
  // register bus
  input  wire logic [`SSW_ADDR_W-1:0] s_axi_awaddr,
  input  wire logic                   s_axi_awvalid,
  output logic                        s_axi_awready,
  input  wire logic [31:0]            s_axi_wdata,
  input  wire logic [3:0]             s_axi_wstrb,
  input  wire logic                   s_axi_wvalid,
  output logic                        s_axi_wready,
  output logic [1:0]                  s_axi_bresp,
  output logic                        s_axi_bvalid,
  input  wire logic                   s_axi_bready,
  input  wire logic [`SSW_ADDR_W-1:0] s_axi_araddr,
  input  wire logic                   s_axi_arvalid,
  output logic                        s_axi_arready,
  output logic [31:0]                 s_axi_rdata,
  output logic [1:0]                  s_axi_rresp,
  output logic                        s_axi_rvalid,
  input  wire logic                   s_axi_rready
);

  localparam logic [`SSW_CNT_W-1:0] INT_RST_MS =
    LONG_RESET ? `SSW_RST_LONG_MS : `SSW_RST_SHORT_MS;

  ssw_pkg::ssw_state_t state_r;
  ssw_pkg::ssw_state_t state_nxt;
  ssw_pkg::ssw_pins_t  pins;
  ssw_pkg::ssw_pins_t  f;
  logic                ext_mode;
  logic                tick;
  logic                kick_edge;
  logic                wd_active;
  logic [`SSW_CNT_W-1:0] rst_len;
  logic [`SSW_CNT_W-1:0] wd_len;
  logic [`SSW_CNT_W-1:0] rst_inc;
  logic [`SSW_CNT_W-1:0] wd_inc;
  logic [31:0]         status_word;
  logic [31:0]         read_word;
  logic [1:0]          read_resp;

  function automatic ssw_pkg::ssw_state_t init_state();
    ssw_pkg::ssw_state_t s;
    s             = '0;
    s.phase       = ssw_pkg::SSW_HOLD;
    s.long_mode   = 1'b1;
    s.kick_flag   = 1'b1;
    s.reset_n     = 1'b0;
    s.reset       = 1'b1;
    s.supply_ok_n = 1'b1;
    s.sel_out     = 1'b1;
    s.wd_en       = 1'(`SSW_CTRL_RST);
    return s;
  endfunction

  localparam ssw_pkg::ssw_state_t STATE_INIT = init_state();

  always_comb
  begin
    pins.supply_low = supply_low_in;
    pins.in_backup  = main_below_backup;
    pins.warn_ok    = early_warn_input;
    pins.kick_lvl   = kick_input;
    pins.kick_float = kick_input_float;
    pins.tb_sel     = timebase_source_select;
    pins.tb_in      = timebase_input;
    pins.sel_in     = select_in;
  end

  // filtered pin levels and derived timing
  always_comb
  begin
    f        = state_r.flt;
    ext_mode = ~f.tb_sel;
    if (ext_mode)
      tick = f.tb_in & ~state_r.tb_prev;
    else
      tick = (state_r.presc == TICK_CYCLES - 1'b1);
    kick_edge = ~f.kick_float & ~state_r.float_prev &
                (f.kick_lvl != state_r.kick_prev);
    wd_active = ~f.kick_float & state_r.wd_en;
    if (ext_mode)
    begin
      rst_len = EXT_RST_TICKS;
      wd_len  = state_r.long_mode ? EXT_WD_LONG : EXT_WD_SHORT;
    end
    else
    begin
      rst_len = INT_RST_MS;
      if (state_r.long_mode || f.tb_in)
        wd_len = `SSW_WD_LONG_MS;
      else
        wd_len = `SSW_WD_SHORT_MS;
    end
    rst_inc = state_r.rst_cnt + 1'b1;
    wd_inc  = state_r.wd_cnt + 1'b1;
  end

  // register read data
  always_comb
  begin
    status_word                    = '0;
    status_word[`SSW_ST_RESET_N]   = state_r.reset_n;
    status_word[`SSW_ST_SUPPLY_OK] = state_r.supply_ok_n;
    status_word[`SSW_ST_KICK_FLAG] = state_r.kick_flag;
    status_word[`SSW_ST_BACKUP]    = state_r.backup_active;
    status_word[`SSW_ST_WARN]      = state_r.warn_out;
    status_word[`SSW_ST_LONG]      = state_r.long_mode;
    status_word[`SSW_ST_EXT]       = ext_mode;
    status_word[`SSW_ST_WD_ACTIVE] = wd_active;
    read_resp                      = `SSW_RESP_OKAY;
    case (s_axi_araddr)
      `SSW_REG_CTRL:
        read_word = {31'h0000_0000, state_r.wd_en};
      `SSW_REG_STATUS:
        read_word = status_word;
      `SSW_REG_COUNT:
        read_word = {16'h0000, state_r.wd_cnt};
      default:
      begin
        read_word = '0;
        read_resp = `SSW_RESP_SLVERR;
      end
    endcase
  end

  always_comb
  begin
    state_nxt = state_r;

    // three-stage synchroniser, change taken when stages two and three agree
    state_nxt.s1  = pins;
    state_nxt.s2  = state_r.s1;
    state_nxt.s3  = state_r.s2;
    state_nxt.flt = ssw_pkg::ssw_pins_t'((state_r.s2 & state_r.s3) |
                    (state_r.flt & (state_r.s2 ^ state_r.s3)));

    // internal prescaler, one tick per millisecond
    if (ext_mode || tick)
      state_nxt.presc = '0;
    else
      state_nxt.presc = state_r.presc + 1'b1;
    state_nxt.tb_prev    = f.tb_in;
    state_nxt.kick_prev  = f.kick_lvl;
    state_nxt.float_prev = f.kick_float;

    // supervisor sequence
    case (state_r.phase)
      ssw_pkg::SSW_HOLD:
      begin
        if (f.supply_low)
          state_nxt.rst_cnt = '0;
        else if (tick)
        begin
          if (rst_inc >= rst_len)
          begin
            state_nxt.phase     = ssw_pkg::SSW_RUN;
            state_nxt.rst_cnt   = '0;
            state_nxt.wd_cnt    = '0;
            state_nxt.long_mode = 1'b1;
          end
          else
            state_nxt.rst_cnt = rst_inc;
        end
      end
      ssw_pkg::SSW_RUN:
      begin
        if (f.supply_low)
        begin
          state_nxt.phase   = ssw_pkg::SSW_HOLD;
          state_nxt.rst_cnt = '0;
        end
        else if (!wd_active)
          state_nxt.wd_cnt = '0;
        else if (kick_edge)
        begin
          state_nxt.wd_cnt    = '0;
          state_nxt.long_mode = 1'b0;
        end
        else if (tick)
        begin
          if (wd_inc >= wd_len)
          begin
            state_nxt.phase     = ssw_pkg::SSW_HOLD;
            state_nxt.rst_cnt   = '0;
            state_nxt.wd_cnt    = '0;
            state_nxt.kick_flag = 1'b0;
          end
          else
            state_nxt.wd_cnt = wd_inc;
        end
      end
      default:
      begin
        state_nxt.phase   = ssw_pkg::SSW_HOLD;
        state_nxt.rst_cnt = '0;
      end
    endcase

    // raising the timeout flag wins over expiry in the same cycle
    if (kick_edge)
      state_nxt.kick_flag = 1'b1;
    if (f.kick_float)
      state_nxt.kick_flag = 1'b1;
    if (f.supply_low)
      state_nxt.kick_flag = 1'b1;

    // pin outputs
    state_nxt.reset_n       = (state_nxt.phase == ssw_pkg::SSW_RUN);
    state_nxt.reset         = ~state_nxt.reset_n;
    state_nxt.supply_ok_n   = ~f.supply_low;
    state_nxt.backup_active = f.in_backup;
    state_nxt.warn_out      = f.warn_ok & ~f.in_backup;
    state_nxt.sel_out       = f.supply_low | f.sel_in;

    // write channel: address and data taken in either order
    if (s_axi_awvalid && !state_r.aw_held)
    begin
      state_nxt.aw_held = 1'b1;
      state_nxt.awaddr  = s_axi_awaddr;
    end
    if (s_axi_wvalid && !state_r.w_held)
    begin
      state_nxt.w_held = 1'b1;
      state_nxt.wdata  = s_axi_wdata;
      state_nxt.wstrb  = s_axi_wstrb;
    end
    if (state_r.bvalid && s_axi_bready)
      state_nxt.bvalid = 1'b0;
    if (state_r.aw_held && state_r.w_held && !state_r.bvalid)
    begin
      state_nxt.aw_held = 1'b0;
      state_nxt.w_held  = 1'b0;
      state_nxt.bvalid  = 1'b1;
      state_nxt.bresp   = `SSW_RESP_OKAY;
      case (state_r.awaddr)
        `SSW_REG_CTRL:
        begin
          if (state_r.wstrb[0])
            state_nxt.wd_en = state_r.wdata[`SSW_CTRL_WD_EN];
        end
        `SSW_REG_STATUS,
        `SSW_REG_COUNT:
          state_nxt.bresp = `SSW_RESP_OKAY;
        default:
          state_nxt.bresp = `SSW_RESP_SLVERR;
      endcase
    end

    // read channel
    if (state_r.rvalid)
    begin
      if (s_axi_rready)
        state_nxt.rvalid = 1'b0;
    end
    else if (s_axi_arvalid)
    begin
      state_nxt.rvalid = 1'b1;
      state_nxt.rdata  = read_word;
      state_nxt.rresp  = read_resp;
    end
  end

  always_ff @(posedge aclk)
  begin
    if (!aresetn)
      state_r <= STATE_INIT;
    else
      state_r <= state_nxt;
  end

  assign reset_n            = state_r.reset_n;
  assign reset              = state_r.reset;
  assign supply_low_flag_n  = state_r.supply_ok_n;
  assign kick_timeout_flag  = state_r.kick_flag;
  assign backup_active_flag = state_r.backup_active;
  assign early_warn_output  = state_r.warn_out;
  assign select_out         = state_r.sel_out;
  assign s_axi_awready      = ~state_r.aw_held;
  assign s_axi_wready       = ~state_r.w_held;
  assign s_axi_bvalid       = state_r.bvalid;
  assign s_axi_bresp        = state_r.bresp;
  assign s_axi_arready      = ~state_r.rvalid;
  assign s_axi_rvalid       = state_r.rvalid;
  assign s_axi_rdata        = state_r.rdata;
  assign s_axi_rresp        = state_r.rresp;

endmodule

// File: testbench/ssw_cpu_model.sv
// processor model that services the kick input
// assumes kicks are wanted only while reset is released
`timescale 1ns/1ps
module ssw_cpu_model #(
  parameter int PERIOD = 200
) (
  input  wire logic aclk,
  input  wire logic reset_n,
  input  wire logic enable,
  output logic      kick_input
);
  int cnt;
  initial kick_input = 1'b0;
  always @(posedge aclk)
  begin
    if (!reset_n || !enable)
    begin
      cnt <= 0;
    end
    else if (cnt == PERIOD - 1)
    begin
      cnt <= 0;
      kick_input <= !kick_input;
    end
    else
    begin
      cnt <= cnt + 1;
    end
  end
endmodule

// File: testbench/ssw_props.sv
// assertions on the supervisor outputs of ssw_top
// assumes internal timebase whenever reset widths are judged
`timescale 1ns/1ps
module ssw_props #(
  parameter int TICK_CYCLES = 4,
  parameter bit LONG_RESET  = 1'b0
) (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic supply_low_in,
  input wire logic main_below_backup,
  input wire logic early_warn_input,
  input wire logic kick_input_float,
  input wire logic timebase_source_select,
  input wire logic select_in,
  input wire logic reset_n,
  input wire logic reset,
  input wire logic supply_low_flag_n,
  input wire logic kick_timeout_flag,
  input wire logic backup_active_flag,
  input wire logic early_warn_output,
  input wire logic select_out
);
  localparam int RST_CYC = (LONG_RESET ? 200 : 50) * TICK_CYCLES;
  logic [15:0] lo_cnt_r;
  logic [15:0] lo_cnt_nxt;

  default clocking cb @(posedge aclk);
  endclocking
  default disable iff (!aresetn);

  // cycles of reset held while supply is good
  always_comb
  begin
    lo_cnt_nxt = 16'h0000;
    if (!reset_n && supply_low_flag_n && timebase_source_select)
    begin
      lo_cnt_nxt = lo_cnt_r + 16'h0001;
    end
  end
  always_ff @(posedge aclk)
  begin
    lo_cnt_r <= aresetn ? lo_cnt_nxt : 16'h0000;
  end

  sequence s_low;
    supply_low_in [*8];
  endsequence
  sequence s_float;
    kick_input_float [*8];
  endsequence

  property p_inv;
    reset == !reset_n;
  endproperty
  property p_bkp;
    $stable(main_below_backup) [*8]
      |-> backup_active_flag == main_below_backup;
  endproperty
  property p_flag;
    $stable(supply_low_in) [*8] |-> supply_low_flag_n != supply_low_in;
  endproperty
  property p_warn;
    $stable({early_warn_input, main_below_backup}) [*8]
      |-> early_warn_output == (early_warn_input && !main_below_backup);
  endproperty
  property p_sel;
    $stable({select_in, supply_low_in}) [*8]
      |-> select_out == (select_in || supply_low_in);
  endproperty
  property p_low;
    s_low |-> !reset_n && kick_timeout_flag;
  endproperty
  property p_float;
    s_float |-> kick_timeout_flag;
  endproperty
  property p_exp;
    $fell(kick_timeout_flag) |-> ##[0:2] !reset_n;
  endproperty
  property p_width;
    $rose(reset_n) && timebase_source_select
      |-> lo_cnt_r >= RST_CYC - 8 && lo_cnt_r <= RST_CYC + 8;
  endproperty

  a_inv: assert property (p_inv)
    else $error("reset outputs disagree");
  a_bkp: assert property (p_bkp)
    else $error("backup flag wrong");
  a_flag: assert property (p_flag)
    else $error("supply low flag wrong");
  a_warn: assert property (p_warn)
    else $error("early warn output wrong");
  a_sel: assert property (p_sel)
    else $error("select output wrong");
  a_low: assert property (p_low)
    else $error("low supply outputs wrong");
  a_float: assert property (p_float)
    else $error("timeout flag low while floating");
  a_exp: assert property (p_exp)
    else $error("expiry without reset");
  a_width: assert property (p_width)
    else $error("reset width wrong");
endmodule

bind ssw_top ssw_props #(
  .TICK_CYCLES(TICK_CYCLES),
  .LONG_RESET (LONG_RESET)
) u_ssw_props (
  .aclk, .aresetn, .supply_low_in, .main_below_backup, .early_warn_input,
  .kick_input_float, .timebase_source_select, .select_in, .reset_n,
  .reset, .supply_low_flag_n, .kick_timeout_flag, .backup_active_flag,
  .early_warn_output, .select_out
);

// File: testbench/testbench.sv
// self-checking bench for ssw_top with a processor model
// assumes a 4 cycle internal tick and a 10 cycle external tick
`timescale 1ns/1ps
`include "ssw_cfg.svh"
module testbench;
  logic        aclk, aresetn, supply_low_in, main_below_backup;
  logic        early_warn_input, kick_input, kick_input_float;
  logic        timebase_source_select, timebase_input, select_in;
  logic        reset_n, reset, supply_low_flag_n, kick_timeout_flag;
  logic        backup_active_flag, early_warn_output, select_out;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic        s_axi_rvalid, s_axi_rready, kick_en, ext_run;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, rd;
  logic [3:0]  s_axi_wstrb;
  logic [1:0]  s_axi_bresp, s_axi_rresp, rsp;
  int          errors, samples_checked, n, m, w, s, l;

  ssw_top #(
    .TICK_CYCLES  (16'h0004),
    .EXT_RST_TICKS(16'h0008),
    .EXT_WD_SHORT (16'h0014),
    .EXT_WD_LONG  (16'h0028)
  ) u_ssw_top (.*);

  ssw_cpu_model u_ssw_cpu_model (
    .aclk      (aclk),
    .reset_n   (reset_n),
    .enable    (kick_en),
    .kick_input(kick_input)
  );

  always #20 aclk = !aclk;

  // external tick, one edge every 5 clocks
  always @(posedge aclk)
  begin
    repeat (4) @(posedge aclk);
    if (ext_run)
    begin
      timebase_input <= !timebase_input;
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp)
    begin
      errors++;
      $display("mismatch at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic wlev(input logic v, input int lim);
    n = 0;
    while (reset_n !== v && n < lim)
    begin
      @(posedge aclk);
      n++;
    end
  endtask

  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    bit pa;
    bit pw;
    @(posedge aclk);
    pa = 1;
    pw = 1;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    s_axi_bready <= 1'b1;
    while (pa || pw)
    begin
      @(posedge aclk);
      pa = pa && !s_axi_awready;
      pw = pw && !s_axi_wready;
      s_axi_awvalid <= pa;
      s_axi_wvalid <= pw;
    end
    while (!s_axi_bvalid) @(posedge aclk);
    rsp = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic axr(input logic [7:0] a);
    @(posedge aclk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    rd = s_axi_rdata;
    rsp = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, errors);
    if (errors == 0 && samples_checked > 0)
    begin
      $display("Testbench passed");
    end
    else
    begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  initial
  begin
    repeat (40000) @(posedge aclk);
    errors++;
    conclude();
  end

  initial
  begin
    {aclk, aresetn, supply_low_in, main_below_backup, kick_input_float} = 0;
    {timebase_input, select_in, ext_run, s_axi_awvalid, s_axi_wvalid} = 0;
    {s_axi_bready, s_axi_arvalid, s_axi_rready, s_axi_awaddr} = 0;
    {s_axi_araddr, s_axi_wdata} = 0;
    {early_warn_input, timebase_source_select, kick_en} = 3'b111;
    s_axi_wstrb = 4'hF;
    n = $urandom(10);
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    #1;
    chk({reset_n, reset, kick_timeout_flag}, 3'b011);
    wlev(1'b1, 400);
    chk(n >= 190 && n <= 215, 1);
    $display("test 1 done");
    wlev(1'b0, 3000);
    chk(n, 3000);
    @(kick_input);
    kick_en <= 1'b0;
    wlev(1'b0, 1000);
    chk(n >= 395 && n <= 420, 1);
    repeat (2) @(posedge aclk);
    chk(kick_timeout_flag, 0);
    wlev(1'b1, 400);
    chk(n >= 185 && n <= 210, 1);
    wlev(1'b0, 8000);
    chk(n >= 6380 && n <= 6420, 1);
    wlev(1'b1, 400);
    kick_en <= 1'b1;
    @(kick_input);
    repeat (8) @(posedge aclk);
    chk(kick_timeout_flag, 1);
    $display("test 2 done");
    kick_en <= 1'b0;
    kick_input_float <= 1'b1;
    wlev(1'b0, 7000);
    chk(n, 7000);
    chk(kick_timeout_flag, 1);
    axr(`SSW_REG_STATUS);
    chk(rd & 32'h0000_00DF, 32'h0000_0017);
    axw(`SSW_REG_CTRL, 32'h0000_0000);
    chk(rsp, `SSW_RESP_OKAY);
    kick_input_float <= 1'b0;
    repeat (20) @(posedge aclk);
    axr(`SSW_REG_COUNT);
    chk(rd, 0);
    axr(`SSW_REG_CTRL);
    chk(rd, 0);
    axw(`SSW_REG_STATUS, 32'hFFFF_FFFF);
    chk(rsp, `SSW_RESP_OKAY);
    axw(8'h10, 32'h0000_0001);
    chk(rsp, `SSW_RESP_SLVERR);
    axr(8'h10);
    chk({30'h0000_0000, rsp}, {30'h0000_0000, `SSW_RESP_SLVERR});
    chk(rd, 32'h0000_0000);
    axw(`SSW_REG_CTRL, 32'h0000_0001);
    $display("test 3 done");
    timebase_source_select <= 1'b0;
    ext_run <= 1'b1;
    supply_low_in <= 1'b1;
    repeat (20) @(posedge aclk);
    chk({supply_low_flag_n, reset_n}, 0);
    chk({kick_timeout_flag, select_out}, 3);
    supply_low_in <= 1'b0;
    wlev(1'b1, 300);
    chk(n >= 75 && n <= 105, 1);
    wlev(1'b0, 800);
    chk(n >= 385 && n <= 420, 1);
    $display("test 4 done");
    repeat (16)
    begin
      {m, w, s, l} = {$urandom % 2, $urandom % 2, $urandom % 2, $urandom % 2};
      main_below_backup <= m[0];
      early_warn_input <= w[0];
      select_in <= s[0];
      supply_low_in <= l[0];
      repeat (8) @(posedge aclk);
      chk(backup_active_flag, m);
      chk(early_warn_output, w & ~m & 1);
      chk(select_out, s | l);
      chk(supply_low_flag_n, !l);
    end
    $display("test 5 done");
    conclude();
  end
endmodule
